// File: design/clc_regs.sv
// AXI4-Lite register bank holding the closed-loop motor configuration words.
`default_nettype none
module clc_regs
  import clc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motor_driven,
  input wire logic closed_loop_active,
  input wire logic first_attempt,
  input wire logic [15:0] backemf_abs_uv,
  input wire logic speed_pulse_raw,
  output logic speed_pulse_output,
  output logic modulation_type,
  output logic surge_protect_enable,
  output logic deadtime_comp_enable,
  output logic speed_regulator_off,
  output logic [2:0] stop_method,
  output logic stop_method_valid,
  output logic [18:0] brake_duration_units,
  output logic [3:0] spin_down_threshold,
  output logic [9:0] brake_speed_permille,
  output logic [7:0] phase_resistance,
  output logic [7:0] phase_inductance,
  output logic config_parity
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  // All state of the bank in one record.
  typedef struct packed {
    logic [31:0] one;
    logic [31:0] two;
    logic aw_held;
    logic [9:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] div_count;
    logic pulse_prev;
    logic pulse_out;
    logic below_thr;
  } clc_state_type;

  clc_state_type state_reg; // Registered state.
  clc_state_type state_next; // Next state.

  logic [3:0] divide_ratio; // Effective divide ratio.
  logic [15:0] thr_uv; // Decoded back-EMF threshold.
  logic thr_valid; // Threshold code is usable.
  logic src_valid; // Output-mode code is defined.

  ////////////////////////////////////////////////////////////////////////////////
  // Field decoder.

  clc_decode u_decode (
    .word_one(state_reg.one),
    .word_two(state_reg.two),
    .divide_ratio(divide_ratio),
    .backemf_thr_uv(thr_uv),
    .threshold_valid(thr_valid),
    .brake_units(brake_duration_units),
    .stop_valid(stop_method_valid),
    .source_valid(src_valid),
    .brake_speed_permille(brake_speed_permille)
  );

  // Merges write data into a word under byte strobes and a writable mask.
  function automatic logic [31:0] clc_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : clc_merge

  // Register picked by a byte address; the two low bits only name a byte inside the word.
  function automatic logic [1:0] clc_select(input logic [9:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[9:2] == CLC_IDX_ONE)
    begin
      sel = 2'h1;
    end
    else if (addr[9:2] == CLC_IDX_TWO)
    begin
      sel = 2'h2;
    end
    else if (addr[9:2] == CLC_IDX_STATUS)
    begin
      sel = 2'h3;
    end
    return sel;
  endfunction : clc_select

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Bus handling and speed-pulse shaping.
  always_comb
  begin
    logic pulse_allowed;
    logic raw_edge;
    logic [1:0] sel;
    pulse_allowed = 1'b0;
    raw_edge = 1'b0;
    sel = 2'h0;
    state_next = state_reg;

    // Capture write address and data in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end

    // Perform the write once both halves are present.
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid)
    begin
      sel = clc_select(state_reg.aw_addr);
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = CLC_RESP_OKAY;
      if (sel == 2'h1)
      begin
        // Reserved bit 0 is stored as written; software keeps it.
        state_next.one = clc_merge(state_reg.one, state_reg.w_data, state_reg.w_strb, CLC_MASK_ONE);
      end
      else if (sel == 2'h2)
      begin
        state_next.two = clc_merge(state_reg.two, state_reg.w_data, state_reg.w_strb, CLC_MASK_TWO);
      end
      else
      begin
        state_next.bresp = CLC_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready)
    begin
      sel = clc_select(s_axi_araddr);
      state_next.rvalid = 1'b1;
      state_next.rresp = CLC_RESP_OKAY;
      unique case (sel)
        2'h1: state_next.rdata = state_reg.one;
        2'h2: state_next.rdata = state_reg.two;
        2'h3: state_next.rdata = {28'h0, state_reg.below_thr, state_reg.pulse_out, src_valid, thr_valid};
        default:
        begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = CLC_RESP_SLVERR;
        end
      endcase
    end
    else if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end

    // Back-EMF comparison for gated output.
    state_next.below_thr = thr_valid && (backemf_abs_uv < thr_uv);

    // Output window by selected mode.
    unique case (state_reg.one[CLC_SRC_LSB +: 2])
      CLC_SRC_BOTH: pulse_allowed = motor_driven;
      CLC_SRC_CLOSED: pulse_allowed = motor_driven && closed_loop_active;
      CLC_SRC_FIRST_OPEN: pulse_allowed = motor_driven && (closed_loop_active || first_attempt);
      default: pulse_allowed = 1'b0;
    endcase
    // Gating: stop once back-EMF falls below threshold.
    if (state_reg.one[CLC_GATE_POS] && state_reg.below_thr)
    begin
      pulse_allowed = 1'b0;
    end

    // Divide: toggle output every ratio edges of the raw pulse, either direction.
    // Counting both edges makes the output period ratio raw periods, so ratio one follows the raw pulse.
    state_next.pulse_prev = speed_pulse_raw;
    raw_edge = speed_pulse_raw != state_reg.pulse_prev;
    if (!pulse_allowed)
    begin
      state_next.div_count = 4'h0;
      state_next.pulse_out = 1'b0;
    end
    else if (raw_edge)
    begin
      if (state_reg.div_count + 4'h1 >= divide_ratio)
      begin
        state_next.div_count = 4'h0;
        state_next.pulse_out = ~state_reg.pulse_out;
      end
      else
      begin
        state_next.div_count = state_reg.div_count + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous active-low reset to documented values.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.one <= CLC_RST_ONE;
      state_reg.two <= CLC_RST_TWO;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Handshake readies are combinational; one transfer at a time each way.
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // Field outputs straight from the stored words, and the shaped speed pulse from its register.
  assign speed_pulse_output = state_reg.pulse_out;
  assign modulation_type = state_reg.one[CLC_MOD_POS];
  assign surge_protect_enable = state_reg.one[CLC_AVS_POS];
  assign deadtime_comp_enable = state_reg.one[CLC_DTC_POS];
  assign speed_regulator_off = state_reg.one[CLC_SPD_POS];
  assign config_parity = state_reg.two[CLC_PAR_POS];
  assign stop_method = state_reg.two[CLC_STOP_LSB +: 3];
  assign spin_down_threshold = state_reg.two[CLC_SPIN_LSB +: 4];
  assign phase_resistance = state_reg.two[CLC_RES_LSB +: 8];
  assign phase_inductance = state_reg.two[CLC_IND_LSB +: 8];

endmodule : clc_regs
`default_nettype wire

// File: design/clc_pkg.sv
// Package of constants and types for the closed-loop configuration register bank.
`default_nettype none
package clc_pkg;
  // Register indices; each register is one aligned word at four times its index.
  localparam logic [7:0] CLC_IDX_ONE = 8'h88;
  localparam logic [7:0] CLC_IDX_TWO = 8'h8A;
  localparam logic [7:0] CLC_IDX_STATUS = 8'h90;
  // Byte addresses on the register bus, four times the index.
  localparam logic [9:0] CLC_OFF_ONE = 10'h220;
  localparam logic [9:0] CLC_OFF_TWO = 10'h228;
  localparam logic [9:0] CLC_OFF_STATUS = 10'h240;
  // Field positions of the first word.
  localparam int CLC_MOD_POS = 14;
  localparam int CLC_SRC_LSB = 12;
  localparam int CLC_DIV_LSB = 8;
  localparam int CLC_GATE_POS = 7;
  localparam int CLC_THR_LSB = 4;
  localparam int CLC_AVS_POS = 3;
  localparam int CLC_DTC_POS = 2;
  localparam int CLC_SPD_POS = 1;
  // Field positions of the second word.
  localparam int CLC_PAR_POS = 31;
  localparam int CLC_STOP_LSB = 28;
  localparam int CLC_BRK_LSB = 24;
  localparam int CLC_SPIN_LSB = 20;
  localparam int CLC_BSPD_LSB = 16;
  localparam int CLC_RES_LSB = 8;
  localparam int CLC_IND_LSB = 0;
  // Reset values; undefined fields are taken as zero.
  localparam logic [31:0] CLC_RST_ONE = 32'h0000_0000;
  localparam logic [31:0] CLC_RST_TWO = 32'h0000_0000;
  // Writable masks: word one holds bits 14..0, word two all bits.
  localparam logic [31:0] CLC_MASK_ONE = 32'h0000_7FFF;
  localparam logic [31:0] CLC_MASK_TWO = 32'hFFFF_FFFF;
  // AXI response codes.
  localparam logic [1:0] CLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLC_RESP_SLVERR = 2'h2;
  // Clock rate and brake-time table unit.
  localparam int CLC_CLK_MHZ = 100;
  localparam int CLC_BRK_UNIT_US = 50;
  localparam int CLC_BRK_UNIT_CYC = CLC_BRK_UNIT_US * CLC_CLK_MHZ;
  // Stop methods.
  typedef enum logic [2:0] {
    CLC_STOP_HIZ = 3'h0,
    CLC_STOP_RECIRC = 3'h1,
    CLC_STOP_LOW_BRAKE = 3'h2,
    CLC_STOP_HIGH_BRAKE = 3'h3,
    CLC_STOP_SPIN_DOWN = 3'h4,
    CLC_STOP_ALIGN = 3'h5
  } clc_stop_type;
  // Speed-pulse output modes.
  typedef enum logic [1:0] {
    CLC_SRC_BOTH = 2'h0,
    CLC_SRC_CLOSED = 2'h1,
    CLC_SRC_FIRST_OPEN = 2'h2
  } clc_src_type;
endpackage : clc_pkg
`default_nettype wire

// File: design/clc_decode.sv
// Decoder that turns the stored fields into the values the motor algorithm uses.
`default_nettype none
module clc_decode
  import clc_pkg::*;
(
  input wire logic [31:0] word_one,
  input wire logic [31:0] word_two,
  output logic [3:0] divide_ratio,
  output logic [15:0] backemf_thr_uv,
  output logic threshold_valid,
  output logic [18:0] brake_units,
  output logic stop_valid,
  output logic source_valid,
  output logic [9:0] brake_speed_permille
);
  // Brake time in 50 us units for each code.
  function automatic logic [18:0] clc_brake_units(input logic [3:0] code);
    logic [18:0] u;
    u = 19'h00000;
    unique case (code)
      4'h0, 4'h1: u = 19'h00002;
      4'h2: u = 19'h00005;
      4'h3: u = 19'h0000A;
      4'h4: u = 19'h00014;
      4'h5: u = 19'h00064;
      4'h6: u = 19'h000C8;
      4'h7: u = 19'h003E8;
      4'h8: u = 19'h007D0;
      4'h9: u = 19'h01388;
      4'hA: u = 19'h02710;
      4'hB: u = 19'h04E20;
      4'hC: u = 19'h0C350;
      4'hD: u = 19'h186A0;
      4'hE: u = 19'h30D40;
      4'hF: u = 19'h493E0;
    endcase
    return u;
  endfunction : clc_brake_units

  // Combinational decode of the divide, threshold, brake, stop, source and brake-speed fields.
  always_comb
  begin
    // Codes 0 and 1 both divide by one.
    divide_ratio = (word_one[CLC_DIV_LSB +: 4] < 4'h2) ? 4'h1 : word_one[CLC_DIV_LSB +: 4];
    threshold_valid = (word_one[CLC_THR_LSB +: 3] < 3'h6);
    unique case (word_one[CLC_THR_LSB +: 3])
      3'h0: backemf_thr_uv = 16'h03E8;
      3'h1: backemf_thr_uv = 16'h07D0;
      3'h2: backemf_thr_uv = 16'h1388;
      3'h3: backemf_thr_uv = 16'h2710;
      3'h4: backemf_thr_uv = 16'h4E20;
      3'h5: backemf_thr_uv = 16'h7530;
      default: backemf_thr_uv = 16'h0000;
    endcase
    // Codes 0 and 1 share one duration; every other code has its own, and the width covers the longest time.
    brake_units = clc_brake_units(word_two[CLC_BRK_LSB +: 4]);
    stop_valid = (word_two[CLC_STOP_LSB +: 3] < 3'h6);
    source_valid = (word_one[CLC_SRC_LSB +: 2] != 2'h3);
    unique case (word_two[CLC_BSPD_LSB +: 4])
      4'h0: brake_speed_permille = 10'd1000;
      4'h1: brake_speed_permille = 10'd900;
      4'h2: brake_speed_permille = 10'd800;
      4'h3: brake_speed_permille = 10'd700;
      4'h4: brake_speed_permille = 10'd600;
      4'h5: brake_speed_permille = 10'd500;
      4'h6: brake_speed_permille = 10'd450;
      4'h7: brake_speed_permille = 10'd400;
      4'h8: brake_speed_permille = 10'd350;
      4'h9: brake_speed_permille = 10'd300;
      4'hA: brake_speed_permille = 10'd250;
      4'hB: brake_speed_permille = 10'd200;
      4'hC: brake_speed_permille = 10'd150;
      4'hD: brake_speed_permille = 10'd100;
      4'hE: brake_speed_permille = 10'd50;
      default: brake_speed_permille = 10'd25;
    endcase
  end
endmodule : clc_decode
`default_nettype wire

// File: verif/clc_regs_monitor.sv
// Checker of bus handshakes and decoded outputs of the closed-loop register bank.
`default_nettype none
module clc_regs_monitor
  import clc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] stop_method,
  input wire logic stop_method_valid,
  input wire logic modulation_type,
  input wire logic config_parity
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks run on the one clock; all but the reset check pause while reset is low.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // A write whose address and data halves are taken on one edge.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A read address taken by the bank.
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_write_answer_time: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer_time: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed while waiting");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_stop_code_valid: assert property (stop_method_valid == (stop_method < 3'h6))
    else $error("stop method validity wrong");
  // Reset is checked here, so this one stays armed during reset.
  a_reset_clears_all: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !modulation_type && stop_method == 3'h0 && !config_parity)
    else $error("state not cleared by reset");
endmodule : clc_regs_monitor
`default_nettype wire

// File: verif/clc_regs_tb.sv
// Self-checking testbench of the closed-loop configuration register bank.
`default_nettype none
module clc_regs_tb
  import clc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus, motor-side stimulus and all observed outputs.
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, motor_driven, closed_loop_active;
  logic first_attempt, speed_pulse_raw, speed_pulse_output, modulation_type, surge_protect_enable;
  logic deadtime_comp_enable, speed_regulator_off, stop_method_valid, config_parity;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0] phase_resistance, phase_inductance;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, spin_down_threshold;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] backemf_abs_uv;
  logic [2:0] stop_method;
  logic [18:0] brake_duration_units;
  logic [9:0] brake_speed_permille;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Cycles a response waits for its ready; zero means ready is offered with the request.
  int late = 0;
  // Expected brake units in 50 us steps and brake speed in permille, by code.
  int brk_tab [16] = '{2, 2, 5, 10, 20, 100, 200, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000, 300000};
  int spd_tab [16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100, 50, 25};
  clc_regs i_clc_regs (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard: a run this long means a handshake never completed.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and stops the run.
  task conclude();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Compares one value and reports a mismatch at once.
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Bus write; both halves are offered together and each dropped once taken.
  task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w, v, done;
    logic [1:0] r;
    int held;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (late == 0);
    done = 1'b0;
    held = 0;
    while (!done)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      v = s_axi_bvalid;
      done = v && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      // A late master lets the response stand for a few edges before taking it.
      if (v && !done)
      begin
        held++;
        if (held >= late)
          s_axi_bready <= 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr
  // Bus read; rready is held until the answer is sampled.
  task rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, v, done;
    logic [31:0] d;
    logic [1:0] r;
    int held;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (late == 0);
    done = 1'b0;
    held = 0;
    while (!done)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      done = v && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar)
        s_axi_arvalid <= 1'b0;
      // A late master lets the read data stand for a few edges before taking it.
      if (v && !done)
      begin
        held++;
        if (held >= late)
          s_axi_rready <= 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk("rdata", d, ed);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  // Cleared words after reset, unmapped and read-only places refused.
  task t_reset_and_map();
    rd(CLC_OFF_ONE, 32'h0, CLC_RESP_OKAY);
    rd(CLC_OFF_TWO, 32'h0, CLC_RESP_OKAY);
    wr(10'h040, 32'hFFFF_FFFF, 4'hF, CLC_RESP_SLVERR);
    rd(10'h040, 32'h0, CLC_RESP_SLVERR);
    // Responses held back by the master must stand unchanged until taken.
    late = 3;
    wr(CLC_OFF_STATUS, 32'hFFFF_FFFF, 4'hF, CLC_RESP_SLVERR);
    // Status: threshold and mode valid, no pulse, zero back-EMF below the 1 mV threshold.
    rd(CLC_OFF_STATUS, 32'h0000_000B, CLC_RESP_OKAY);
    late = 0;
  endtask : t_reset_and_map
  // Word one keeps bits 14..0 only and drives the enable outputs.
  task t_word_one();
    wr(CLC_OFF_ONE, 32'hFFFF_FFFE, 4'hF, CLC_RESP_OKAY);
    rd(CLC_OFF_ONE, 32'h0000_7FFE, CLC_RESP_OKAY);
    chk("flags", {modulation_type, surge_protect_enable, deadtime_comp_enable, speed_regulator_off}, 32'hF);
    wr(CLC_OFF_ONE, 32'h0000_4000, 4'hF, CLC_RESP_OKAY);
    chk("flags", {modulation_type, surge_protect_enable, deadtime_comp_enable, speed_regulator_off}, 32'h8);
  endtask : t_word_one
  // Every code of the second word's stop, brake, spin-down and brake-speed fields, read back and decoded.
  task t_word_two();
    logic [31:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = {i[0], i[2:0], i[3:0], i[3:0], i[3:0], 8'hA5 ^ 8'(i), 8'h3C + 8'(i)};
      wr(CLC_OFF_TWO, v, 4'hF, CLC_RESP_OKAY);
      rd(CLC_OFF_TWO, v, CLC_RESP_OKAY);
      chk("stop", {stop_method_valid, stop_method}, {i[2:0] < 3'h6, i[2:0]});
      chk("brake", brake_duration_units, brk_tab[i]);
      chk("spin", spin_down_threshold, i[3:0]);
      chk("bspeed", brake_speed_permille, spd_tab[i]);
      chk("motor", {config_parity, phase_resistance, phase_inductance}, {i[0], v[15:0]});
    end
    wr(CLC_OFF_TWO, 32'hFFFF_FFFF, 4'hF, CLC_RESP_OKAY);
    wr(CLC_OFF_TWO, 32'h0, 4'h2, CLC_RESP_OKAY);
    rd(CLC_OFF_TWO, 32'hFFFF_00FF, CLC_RESP_OKAY);
  endtask : t_word_two
  // Sends m raw pulses under a word-one setting and counts output toggles.
  task t_pulse(input logic [31:0] w1, input logic cl, input logic [15:0] bemf, input int m, input int exp);
    int n;
    logic prev;
    closed_loop_active <= cl;
    backemf_abs_uv <= bemf;
    wr(CLC_OFF_ONE, w1, 4'hF, CLC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    n = 0;
    @(negedge aclk);
    prev = speed_pulse_output;
    for (int i = 0; i < m * 8 + 6; i++)
    begin
      @(posedge aclk);
      speed_pulse_raw <= (i < m * 8) ? i[2] : 1'b0;
      @(negedge aclk);
      if (speed_pulse_output !== prev)
        n++;
      prev = speed_pulse_output;
    end
    chk("toggles", n, exp);
    @(posedge aclk);
  endtask : t_pulse
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, backemf_abs_uv} = '0;
    {closed_loop_active, speed_pulse_raw} = '0;
    motor_driven = 1'b1;
    first_attempt = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_and_map();
    t_word_one();
    t_word_two();
    t_pulse(32'h0000_0000, 1'b0, 16'h0, 12, 24);
    t_pulse(32'h0000_1100, 1'b0, 16'h0, 12, 0);
    t_pulse(32'h0000_1100, 1'b1, 16'h0, 12, 24);
    t_pulse(32'h0000_2100, 1'b0, 16'h0, 12, 24);
    t_pulse(32'h0000_3100, 1'b1, 16'h0, 12, 0);
    t_pulse(32'h0000_0180, 1'b1, 16'h0, 12, 0);
    t_pulse(32'h0000_01D0, 1'b1, 16'hFFFF, 12, 24);
    t_pulse(32'h0000_01E0, 1'b1, 16'h0, 12, 24);
    t_pulse(32'h0000_0300, 1'b1, 16'h0, 12, 8);
    t_pulse(32'h0000_0F00, 1'b1, 16'h0, 30, 4);
    // Open loop after the first attempt gives no pulses in first-try mode.
    first_attempt <= 1'b0;
    t_pulse(32'h0000_2100, 1'b0, 16'h0, 12, 0);
    // No pulses while the motor is not driven.
    motor_driven <= 1'b0;
    t_pulse(32'h0000_0000, 1'b1, 16'h0, 12, 0);
    conclude();
  end
endmodule : clc_regs_tb
// Attaches the checker to the bank's ports.
bind clc_regs clc_regs_monitor i_clc_regs_monitor (.*);
`default_nettype wire
